/* File: shared/spi_chan_map.svh */
`ifndef SPI_CHAN_MAP_SVH
`define SPI_CHAN_MAP_SVH

// ==========================================================
// word length limits
`define WORD_BITS_MIN   5'h04
`define WORD_BITS_MAX   5'h10
`define WORD_W          16

// ==========================================================
// transfer operations
`define OP_SINGLE       2'h0
`define OP_BULK_WRITE   2'h1
`define OP_BULK_READ    2'h2

// ==========================================================
// mode fields
`define MODE_CPOL_BIT   1
`define MODE_CPHA_BIT   0

// ==========================================================
// rate divider, timing counts and transmit buffer depth
`define DIV_STEPS       6'h20
`define HALF_MIN        16'h0003
`define HALF_MAX        32'h0000ffff
`define LINK_HZ_DEFAULT 32'h00ee6b28
`define FIFO_DEPTH      8

`endif

/* File: shared/spi_chan_pkg.sv */
package spi_chan_pkg;

  // ==========================================================
  // channel control, on the system clock
  typedef enum logic [2:0] {CH_CLOSED, CH_DIVIDE, CH_READY, CH_FETCH, CH_WAIT} ch_state_t;

  typedef struct packed {
    ch_state_t   st;
    logic [1:0]  mode;
    logic [4:0]  bits;
    logic [32:0] divisor;
    logic [31:0] quo;
    logic [32:0] rem;
    logic [5:0]  step;
    logic [15:0] half;
    logic        link_open;
    logic [1:0]  op;
    logic [15:0] left;
    logic [15:0] tx;
    logic        req_tog;
    logic        ack_s1;
    logic        ack_s2;
    logic        ack_seen;
    logic        cmd_ready;
    logic        busy;
    logic        rx_valid;
    logic [15:0] rx_data;
    logic        done;
  } ch_regs_t;

  // ==========================================================
  // link side shifter, on the link clock
  typedef enum logic {LK_IDLE, LK_SHIFT} lk_state_t;

  typedef struct packed {
    lk_state_t   st;
    logic        open_s1;
    logic        open_s2;
    logic        req_s1;
    logic        req_s2;
    logic        miso_s1;
    logic        miso_s2;
    logic        req_seen;
    logic        cpol;
    logic        cpha;
    logic [4:0]  bits;
    logic [15:0] half;
    logic [15:0] cnt;
    logic [5:0]  edge_n;
    logic [15:0] sh;
    logic [15:0] rx;
    logic [15:0] rx_word;
    logic        ack_tog;
    logic        sclk;
    logic        mosi;
    logic        pins_on;
  } lk_regs_t;

endpackage : spi_chan_pkg

/* File: hdl/word_fifo.sv */
`timescale 1ns/1ps
`default_nettype none

module word_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input  wire logic             clk_in,
  input  wire logic             reset_n_in,
  input  wire logic             in_valid_in,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  in_ready_out,
  output logic                  out_valid_out,
  output logic      [WIDTH-1:0] out_data_out,
  input  wire logic             out_ready_in
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wp;
    logic [AW-1:0]               rp;
    logic [CW-1:0]               cnt;
    logic                        in_ready;
    logic                        out_valid;
  } fifo_regs_t;

  localparam fifo_regs_t FIFO_RST = '{mem: '0, wp: '0, rp: '0, cnt: '0, in_ready: 1'b1, out_valid: 1'b0};

  fifo_regs_t r;
  fifo_regs_t n;
  logic       push;
  logic       pop;

  // ==========================================================
  // pointers and flags
  always_comb begin
    n    = r;
    push = in_valid_in && r.in_ready;
    pop  = out_ready_in && r.out_valid;
    if (push) begin
      n.mem[r.wp] = in_data_in;
      n.wp        = (r.wp == AW'(DEPTH - 1)) ? '0 : r.wp + AW'(1);
    end
    if (pop) begin
      n.rp = (r.rp == AW'(DEPTH - 1)) ? '0 : r.rp + AW'(1);
    end
    if (push && !pop) begin
      n.cnt = r.cnt + CW'(1);
    end else if (pop && !push) begin
      n.cnt = r.cnt - CW'(1);
    end
    // flags are registered so the ready seen by the source never ripples
    n.in_ready  = (n.cnt != CW'(DEPTH));
    n.out_valid = (n.cnt != '0);
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      r <= FIFO_RST;
    end else begin
      r <= n;
    end
  end

  assign in_ready_out  = r.in_ready;
  assign out_valid_out = r.out_valid;
  assign out_data_out  = r.mem[r.rp];

endmodule : word_fifo

`default_nettype wire

/* File: hdl/link_shifter.sv */
`timescale 1ns/1ps
`default_nettype none

`include "spi_chan_map.svh"

module link_shifter (
  input  wire logic        link_clk_in,
  input  wire logic        reset_n_in,
  input  wire logic        open_in,
  input  wire logic [1:0]  mode_in,
  input  wire logic [4:0]  bits_in,
  input  wire logic [15:0] half_in,
  input  wire logic        req_tog_in,
  input  wire logic [15:0] tx_word_in,
  output logic             ack_tog_out,
  output logic [15:0]      rx_word_out,
  input  wire logic        miso_in,
  output logic             sclk_out,
  output logic             sclk_oe_out,
  output logic             mosi_out,
  output logic             mosi_oe_out
);

  spi_chan_pkg::lk_regs_t r;
  spi_chan_pkg::lk_regs_t n;

  // ==========================================================
  // bit engine
  always_comb begin
    logic [15:0] load;
    logic [15:0] rx_new;
    logic [5:0]  last;
    logic        leading;
    load    = tx_word_in << (5'h10 - r.bits);
    rx_new  = r.rx;
    last    = ({1'b0, r.bits} << 1) - 6'h01;
    leading = ~r.edge_n[0];
    n         = r;
    n.open_s1 = open_in;
    n.open_s2 = r.open_s1;
    n.req_s1  = req_tog_in;
    n.req_s2  = r.req_s1;
    n.miso_s1 = miso_in;
    n.miso_s2 = r.miso_s1;
    if (!r.open_s2) begin
      // closed: abort and park the pins low, released
      n.st      = spi_chan_pkg::LK_IDLE;
      n.pins_on = 1'b0;
      n.sclk    = 1'b0;
      n.mosi    = 1'b0;
    end else if (!r.pins_on) begin
      // config is quasi-static: stable before open crosses over
      n.pins_on  = 1'b1;
      n.cpol     = mode_in[`MODE_CPOL_BIT];
      n.cpha     = mode_in[`MODE_CPHA_BIT];
      n.bits     = bits_in;
      n.half     = half_in;
      n.sclk     = mode_in[`MODE_CPOL_BIT];
      n.mosi     = 1'b0;
      n.req_seen = r.req_s2;
      n.st       = spi_chan_pkg::LK_IDLE;
    end else begin
      case (r.st)
        spi_chan_pkg::LK_IDLE: begin
          if (r.req_s2 != r.req_seen) begin
            n.req_seen = r.req_s2;
            n.sh       = load;
            n.rx       = '0;
            n.cnt      = '0;
            n.edge_n   = '0;
            n.st       = spi_chan_pkg::LK_SHIFT;
            if (!r.cpha) begin
              n.mosi = load[15];
              n.sh   = load << 1;
            end
          end
        end
        spi_chan_pkg::LK_SHIFT: begin
          if (r.cnt == r.half - 16'h0001) begin
            n.cnt    = '0;
            n.sclk   = ~r.sclk;
            n.edge_n = r.edge_n + 6'h01;
            if (leading ^ r.cpha) begin
              rx_new = {r.rx[14:0], r.miso_s2};
              n.rx   = rx_new;
            end else if (r.edge_n != last) begin
              n.mosi = r.sh[15];
              n.sh   = r.sh << 1;
            end
            if (r.edge_n == last) begin
              n.rx_word = rx_new;
              n.ack_tog = ~r.ack_tog;
              n.st      = spi_chan_pkg::LK_IDLE;
            end
          end else begin
            n.cnt = r.cnt + 16'h0001;
          end
        end
        default: n.st = spi_chan_pkg::LK_IDLE;
      endcase
    end
  end

  always_ff @(posedge link_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign ack_tog_out = r.ack_tog;
  assign rx_word_out = r.rx_word;
  assign sclk_out    = r.sclk;
  assign sclk_oe_out = r.pins_on;
  assign mosi_out    = r.mosi;
  assign mosi_oe_out = r.pins_on;

endmodule : link_shifter

`default_nettype wire

/* File: hdl/spi_master_channel.sv */
`timescale 1ns/1ps
`default_nettype none

`include "spi_chan_map.svh"

module spi_master_channel #(
  parameter int          NUM_CHANNELS = 2,
  parameter logic [31:0] LINK_HZ      = `LINK_HZ_DEFAULT,
  parameter int          FIFO_DEPTH   = `FIFO_DEPTH
) (
  input  wire logic                          CLK_IN,
  input  wire logic                          RESET_N_IN,
  input  wire logic                          LINK_CLK_IN,
  input  wire logic [NUM_CHANNELS-1:0]       OPEN_IN,
  input  wire logic [NUM_CHANNELS-1:0][31:0] SPEED_HZ_IN,
  input  wire logic [NUM_CHANNELS-1:0][1:0]  MODE_IN,
  input  wire logic [NUM_CHANNELS-1:0][4:0]  BITS_IN,
  input  wire logic [NUM_CHANNELS-1:0]       CMD_VALID_IN,
  input  wire logic [NUM_CHANNELS-1:0][1:0]  CMD_OP_IN,
  input  wire logic [NUM_CHANNELS-1:0][15:0] CMD_COUNT_IN,
  output logic      [NUM_CHANNELS-1:0]       CMD_READY_OUT,
  input  wire logic [NUM_CHANNELS-1:0]       TX_VALID_IN,
  input  wire logic [NUM_CHANNELS-1:0][15:0] TX_DATA_IN,
  output logic      [NUM_CHANNELS-1:0]       TX_READY_OUT,
  output logic      [NUM_CHANNELS-1:0]       RX_VALID_OUT,
  output logic      [NUM_CHANNELS-1:0][15:0] RX_DATA_OUT,
  output logic      [NUM_CHANNELS-1:0]       DONE_OUT,
  output logic      [NUM_CHANNELS-1:0]       BUSY_OUT,
  output logic      [NUM_CHANNELS-1:0]       OPENED_OUT,
  output logic      [NUM_CHANNELS-1:0]       SCLK_OUT,
  output logic      [NUM_CHANNELS-1:0]       SCLK_OE_OUT,
  output logic      [NUM_CHANNELS-1:0]       MOSI_OUT,
  output logic      [NUM_CHANNELS-1:0]       MOSI_OE_OUT,
  input  wire logic [NUM_CHANNELS-1:0]       MISO_IN
);

  // chip select is left to the controller; this block has no such pin

  genvar ch;
  generate
    for (ch = 0; ch < NUM_CHANNELS; ch = ch + 1) begin : g_chan
      spi_chan_pkg::ch_regs_t r;
      spi_chan_pkg::ch_regs_t n;
      logic                   fifo_valid;
      logic [15:0]            fifo_data;
      logic                   pop;
      logic                   ack_tog;
      logic [15:0]            rx_word;

      // ==========================================================
      // transmit word buffer
      word_fifo #(
        .WIDTH (`WORD_W),
        .DEPTH (FIFO_DEPTH)
      ) u_fifo (
        .clk_in        (CLK_IN),
        .reset_n_in    (RESET_N_IN),
        .in_valid_in   (TX_VALID_IN[ch]),
        .in_data_in    (TX_DATA_IN[ch]),
        .in_ready_out  (TX_READY_OUT[ch]),
        .out_valid_out (fifo_valid),
        .out_data_out  (fifo_data),
        .out_ready_in  (pop)
      );

      // a bulk read never consumes buffered data, so leftover words stay queued
      assign pop = (r.st == spi_chan_pkg::CH_FETCH) && (r.op != `OP_BULK_READ) && fifo_valid;

      // ==========================================================
      // channel sequencer
      always_comb begin
        logic [32:0] trial;
        trial       = {r.rem[31:0], r.quo[31]};
        n           = r;
        n.rx_valid  = 1'b0;
        n.done      = 1'b0;
        n.ack_s1    = ack_tog;
        n.ack_s2    = r.ack_s1;
        if (!OPEN_IN[ch]) begin
          n.st        = spi_chan_pkg::CH_CLOSED;
          n.link_open = 1'b0;
          n.busy      = 1'b0;
          n.cmd_ready = 1'b0;
        end else begin
          case (r.st)
            spi_chan_pkg::CH_CLOSED: begin
              n.mode    = MODE_IN[ch];
              n.bits    = BITS_IN[ch];
              if (BITS_IN[ch] < `WORD_BITS_MIN) begin
                n.bits = `WORD_BITS_MIN;
              end else if (BITS_IN[ch] > `WORD_BITS_MAX) begin
                n.bits = `WORD_BITS_MAX;
              end
              n.divisor = {SPEED_HZ_IN[ch], 1'b0};
              n.quo     = LINK_HZ;
              n.rem     = '0;
              n.step    = '0;
              n.st      = spi_chan_pkg::CH_DIVIDE;
            end
            spi_chan_pkg::CH_DIVIDE: begin
              // serial restoring divide: half period = link rate / (2 * speed)
              n.quo  = {r.quo[30:0], 1'b0};
              n.rem  = trial;
              if (trial >= r.divisor) begin
                n.rem    = trial - r.divisor;
                n.quo[0] = 1'b1;
              end
              n.step = r.step + 6'h01;
              if (r.step == `DIV_STEPS - 6'h01) begin
                // floor keeps the synchronised sample point inside the bit
                if (n.quo > `HALF_MAX) begin
                  n.half = 16'hffff;
                end else if (n.quo[15:0] < `HALF_MIN) begin
                  n.half = `HALF_MIN;
                end else begin
                  n.half = n.quo[15:0];
                end
                n.link_open = 1'b1;
                n.ack_seen  = r.ack_s2;
                n.cmd_ready = 1'b1;
                n.st        = spi_chan_pkg::CH_READY;
              end
            end
            spi_chan_pkg::CH_READY: begin
              if (CMD_VALID_IN[ch]) begin
                n.op        = CMD_OP_IN[ch];
                n.left      = (CMD_OP_IN[ch] == `OP_SINGLE) ? 16'h0001 : CMD_COUNT_IN[ch];
                n.cmd_ready = 1'b0;
                n.st        = spi_chan_pkg::CH_FETCH;
                if (CMD_OP_IN[ch] != `OP_SINGLE && CMD_COUNT_IN[ch] == 16'h0000) begin
                  n.done      = 1'b1;
                  n.cmd_ready = 1'b1;
                  n.st        = spi_chan_pkg::CH_READY;
                end
              end
            end
            spi_chan_pkg::CH_FETCH: begin
              if (r.op == `OP_BULK_READ || fifo_valid) begin
                n.tx      = (r.op == `OP_BULK_READ) ? 16'h0000 : fifo_data;
                n.req_tog = ~r.req_tog;
                n.busy    = 1'b1;
                n.st      = spi_chan_pkg::CH_WAIT;
              end
            end
            spi_chan_pkg::CH_WAIT: begin
              if (r.ack_s2 != r.ack_seen) begin
                n.ack_seen = r.ack_s2;
                n.busy     = 1'b0;
                n.left     = r.left - 16'h0001;
                if (r.op != `OP_BULK_WRITE) begin
                  n.rx_valid = 1'b1;
                  n.rx_data  = rx_word;
                end
                if (r.left == 16'h0001) begin
                  n.done      = 1'b1;
                  n.cmd_ready = 1'b1;
                  n.st        = spi_chan_pkg::CH_READY;
                end else begin
                  n.st = spi_chan_pkg::CH_FETCH;
                end
              end
            end
            default: n.st = spi_chan_pkg::CH_CLOSED;
          endcase
        end
      end

      always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
          r <= '0;
        end else begin
          r <= n;
        end
      end

      // ==========================================================
      // link side, own clock; words cross by toggle handshake
      link_shifter u_link (
        .link_clk_in (LINK_CLK_IN),
        .reset_n_in  (RESET_N_IN),
        .open_in     (r.link_open),
        .mode_in     (r.mode),
        .bits_in     (r.bits),
        .half_in     (r.half),
        .req_tog_in  (r.req_tog),
        .tx_word_in  (r.tx),
        .ack_tog_out (ack_tog),
        .rx_word_out (rx_word),
        .miso_in     (MISO_IN[ch]),
        .sclk_out    (SCLK_OUT[ch]),
        .sclk_oe_out (SCLK_OE_OUT[ch]),
        .mosi_out    (MOSI_OUT[ch]),
        .mosi_oe_out (MOSI_OE_OUT[ch])
      );

      assign CMD_READY_OUT[ch] = r.cmd_ready;
      assign RX_VALID_OUT[ch]  = r.rx_valid;
      assign RX_DATA_OUT[ch]   = r.rx_data;
      assign DONE_OUT[ch]      = r.done;
      assign BUSY_OUT[ch]      = r.busy;
      assign OPENED_OUT[ch]    = r.link_open;
    end
  endgenerate

endmodule : spi_master_channel

`default_nettype wire

/* File: sim/spi_master_channel_checker.sv */
`timescale 1ns/1ps
`default_nettype none

`include "spi_chan_map.svh"

// ==========================================================
// channel 0 handshake and pin checks
module spi_master_channel_checker #(
  parameter int NUM_CHANNELS = 2
) (
  input wire logic                         CLK_IN,
  input wire logic                         RESET_N_IN,
  input wire logic [NUM_CHANNELS-1:0]      OPEN_IN,
  input wire logic [NUM_CHANNELS-1:0]      CMD_VALID_IN,
  input wire logic [NUM_CHANNELS-1:0][1:0] CMD_OP_IN,
  input wire logic [NUM_CHANNELS-1:0]      CMD_READY_OUT,
  input wire logic [NUM_CHANNELS-1:0]      RX_VALID_OUT,
  input wire logic [NUM_CHANNELS-1:0]      DONE_OUT,
  input wire logic [NUM_CHANNELS-1:0]      BUSY_OUT,
  input wire logic [NUM_CHANNELS-1:0]      OPENED_OUT,
  input wire logic [NUM_CHANNELS-1:0]      SCLK_OUT,
  input wire logic [NUM_CHANNELS-1:0]      SCLK_OE_OUT,
  input wire logic [NUM_CHANNELS-1:0]      MOSI_OUT,
  input wire logic [NUM_CHANNELS-1:0]      MOSI_OE_OUT
);
  // saturating counts: pins lag the system side by a few link clocks
  logic [5:0] shut_cnt_r;
  logic [5:0] live_cnt_r;
  logic       wr_cmd_r;

  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      shut_cnt_r <= 6'h00;
      live_cnt_r <= 6'h00;
      wr_cmd_r   <= 1'b0;
    end else begin
      shut_cnt_r <= OPEN_IN[0] ? 6'h00 : shut_cnt_r + {5'h00, shut_cnt_r != 6'h3f};
      live_cnt_r <= !OPENED_OUT[0] ? 6'h00 : live_cnt_r + {5'h00, live_cnt_r != 6'h3f};
      if (CMD_VALID_IN[0] && CMD_READY_OUT[0]) begin
        wr_cmd_r <= (CMD_OP_IN[0] == `OP_BULK_WRITE);
      end
    end
  end

  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RESET_N_IN);

  sequence open_seen;
    $rose(OPEN_IN[0]) && !OPENED_OUT[0];
  endsequence
  sequence ready_late;
    ##1 !OPENED_OUT[0] [*8] ##[25:26] (OPENED_OUT[0] && CMD_READY_OUT[0]);
  endsequence

  chk_open_delay: assert property (open_seen |-> ready_late)
    else $error("open did not complete on time");
  chk_cmd_taken: assert property ((CMD_VALID_IN[0] && CMD_READY_OUT[0]) |=> (!CMD_READY_OUT[0] || DONE_OUT[0]))
    else $error("command taken but ready stayed up");
  chk_busy_excl: assert property (BUSY_OUT[0] |-> !CMD_READY_OUT[0] && !DONE_OUT[0])
    else $error("busy together with ready or done");
  chk_done_pulse: assert property (DONE_OUT[0] |-> CMD_READY_OUT[0] ##1 !DONE_OUT[0])
    else $error("done not a single pulse with ready");
  chk_rx_pulse: assert property ($rose(RX_VALID_OUT[0]) |=> !RX_VALID_OUT[0])
    else $error("receive valid longer than one cycle");
  chk_write_quiet: assert property (wr_cmd_r |-> !RX_VALID_OUT[0])
    else $error("received word delivered during bulk write");
  chk_pins_shut: assert property ((shut_cnt_r == 6'h3f) |-> !(SCLK_OE_OUT[0] || MOSI_OE_OUT[0] || SCLK_OUT[0] || MOSI_OUT[0]))
    else $error("pins not released after close");
  chk_pins_live: assert property ((live_cnt_r == 6'h3f) |-> SCLK_OE_OUT[0] && MOSI_OE_OUT[0])
    else $error("pins not driven while open");
  chk_closed_idle: assert property ($fell(OPEN_IN[0]) |-> ##[1:2] !OPENED_OUT[0] ##1 (!CMD_READY_OUT[0] && !DONE_OUT[0]) [*3])
    else $error("channel still active after close");
endmodule : spi_master_channel_checker

`default_nettype wire

/* File: sim/spi_slave_model.sv */
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// slave chip: answers from tx_mem, logs words received
module spi_slave_model (
  input wire logic       sclk_in,
  input wire logic       mosi_in,
  input wire logic       cs_n_in,
  input wire logic [1:0] mode_in,
  input wire logic [4:0] bits_in,
  output logic           miso_out
);
  logic [15:0] tx_mem[16];
  logic [15:0] rx_q[$];
  logic [15:0] sh;
  int          k;
  int          n;
  realtime     t_last;
  realtime     per;

  function automatic logic nxt_bit();
    return tx_mem[n % 16][int'(bits_in) - 1 - k];
  endfunction : nxt_bit

  initial miso_out = 1'b0;
  always @(negedge cs_n_in) begin
    k = 0;
    n = 0;
    sh = 16'h0000;
    miso_out = nxt_bit();
  end
  // released line: no pull, so show the inverse rather than a stale bit
  always @(posedge cs_n_in) miso_out = ~miso_out;

  always @(sclk_in) begin
    if (!cs_n_in) begin
      if (sclk_in == (mode_in[1] ~^ mode_in[0])) begin
        sh = {sh[14:0], mosi_in};
        k++;
        per = $realtime - t_last;
        t_last = $realtime;
        if (k == int'(bits_in)) begin
          rx_q.push_back(sh);
          k = 0;
          n++;
          sh = 16'h0000;
        end
      end else begin
        miso_out = nxt_bit();
      end
    end
  end
endmodule : spi_slave_model

`default_nettype wire

/* File: sim/tb_spi_master_channel.sv */
`timescale 1ns/1ps
`default_nettype none

`include "spi_chan_map.svh"

// ==========================================================
// bench top
module tb_spi_master_channel;
  localparam logic [31:0] SPD0 = 32'h001dcd65;
  logic             clk;
  logic             link_clk;
  logic             reset_n;
  logic [1:0]       open_ch, cmd_valid, tx_valid, cs_n;
  logic [1:0]       cmd_ready, tx_ready, rx_valid, done, busy, opened, sclk, sclk_oe, mosi, mosi_oe;
  wire  [1:0]       miso;
  logic [1:0][31:0] speed;
  logic [1:0][1:0]  mode, cmd_op;
  logic [1:0][4:0]  bits;
  logic [1:0][15:0] cmd_count, tx_data, rx_data;
  logic [15:0]      got_q[2][$];
  logic [4:0]       bit_tbl[4] = '{5'h04, 5'h08, 5'h0d, 5'h10};
  int               done_cnt[2];
  int               errors;
  int               comparisons;
  int               d0;
  logic [15:0]      mk;

  spi_master_channel #(.NUM_CHANNELS(2)) spi_master_channel_i (
    .CLK_IN(clk), .RESET_N_IN(reset_n), .LINK_CLK_IN(link_clk), .OPEN_IN(open_ch), .SPEED_HZ_IN(speed),
    .MODE_IN(mode), .BITS_IN(bits), .CMD_VALID_IN(cmd_valid), .CMD_OP_IN(cmd_op), .CMD_COUNT_IN(cmd_count),
    .CMD_READY_OUT(cmd_ready), .TX_VALID_IN(tx_valid), .TX_DATA_IN(tx_data), .TX_READY_OUT(tx_ready),
    .RX_VALID_OUT(rx_valid), .RX_DATA_OUT(rx_data), .DONE_OUT(done), .BUSY_OUT(busy), .OPENED_OUT(opened),
    .SCLK_OUT(sclk), .SCLK_OE_OUT(sclk_oe), .MOSI_OUT(mosi), .MOSI_OE_OUT(mosi_oe), .MISO_IN(miso)
  );

  for (genvar c = 0; c < 2; c++) begin : g_slv
    spi_slave_model spi_slave_model_i (
      .sclk_in(sclk[c]), .mosi_in(mosi[c]), .cs_n_in(cs_n[c]), .mode_in(mode[c]), .bits_in(bits[c]),
      .miso_out(miso[c])
    );
  end

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // link clock offset by 13 ns; its 64 ns period lets edges drift across the system clock
  initial begin
    link_clk = 1'b0;
    #13;
    forever #32 link_clk = ~link_clk;
  end

  // no back-pressure on receive: every pulse must be caught
  always @(posedge clk) begin
    for (int c = 0; c < 2; c++) begin
      if (rx_valid[c]) got_q[c].push_back(rx_data[c]);
      if (done[c]) done_cnt[c]++;
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask : check

  function automatic logic [15:0] take(input int ch);
    return (got_q[ch].size() > 0) ? got_q[ch].pop_front() : 16'hxxxx;
  endfunction : take

  function automatic logic [15:0] slave_rx(input int ch);
    if (ch == 0 && g_slv[0].spi_slave_model_i.rx_q.size() > 0) return g_slv[0].spi_slave_model_i.rx_q.pop_front();
    if (ch == 1 && g_slv[1].spi_slave_model_i.rx_q.size() > 0) return g_slv[1].spi_slave_model_i.rx_q.pop_front();
    return 16'hxxxx;
  endfunction : slave_rx

  function automatic logic [15:0] slave_per(input int ch);
    return 16'(int'(ch == 0 ? g_slv[0].spi_slave_model_i.per : g_slv[1].spi_slave_model_i.per));
  endfunction : slave_per

  task automatic slave_words(input int ch, input logic [15:0] base);
    for (int i = 0; i < 16; i++) begin
      if (ch == 0) g_slv[0].spi_slave_model_i.tx_mem[i] = base + 16'(i);
      else g_slv[1].spi_slave_model_i.tx_mem[i] = base + 16'(i);
    end
  endtask : slave_words

  task automatic open_chan(input int ch, input logic [31:0] hz, input logic [1:0] md, input logic [4:0] nb);
    speed[ch]   <= hz;
    mode[ch]    <= md;
    bits[ch]    <= nb;
    open_ch[ch] <= 1'b1;
    for (int i = 0; i < 100 && opened[ch] !== 1'b1; i++) @(posedge clk);
    repeat (40) @(posedge clk);
    cs_n[ch] <= 1'b0;
    @(posedge clk);
  endtask : open_chan

  task automatic close_chan(input int ch);
    cs_n[ch]    <= 1'b1;
    open_ch[ch] <= 1'b0;
    repeat (80) @(posedge clk);
    check(16'({sclk_oe[ch], mosi_oe[ch], sclk[ch], mosi[ch], opened[ch]}), 16'h0000);
  endtask : close_chan

  task automatic push(input int ch, input logic [15:0] d);
    tx_valid[ch] <= 1'b1;
    tx_data[ch]  <= d;
    do @(posedge clk); while (tx_ready[ch] !== 1'b1);
    tx_valid[ch] <= 1'b0;
    @(posedge clk);
  endtask : push

  task automatic command(input int ch, input logic [1:0] op, input logic [15:0] cnt);
    cmd_valid[ch] <= 1'b1;
    cmd_op[ch]    <= op;
    cmd_count[ch] <= cnt;
    d0 = done_cnt[ch];
    do @(posedge clk); while (cmd_ready[ch] !== 1'b1);
    cmd_valid[ch] <= 1'b0;
    for (int i = 0; i < 20000 && done_cnt[ch] == d0; i++) @(posedge clk);
    check(16'(done_cnt[ch] - d0), 16'h0001);
  endtask : command

  task automatic close_out();
    $display("comparisons %0d, errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : close_out

  // ==========================================================
  // test sequence
  initial begin
    reset_n = 1'b0;
    cs_n = 2'h3;
    {open_ch, cmd_valid, tx_valid} = '0;
    {speed, mode, bits, cmd_op, cmd_count, tx_data} = '0;
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    check(16'({tx_ready, opened, sclk_oe, mosi_oe}), 16'h00c0);
    $display("test reset done");
    for (int m = 0; m < 4; m++) begin
      mk = 16'hffff >> (5'h10 - bit_tbl[m]);
      slave_words(0, 16'hb6e9 + 16'(m));
      open_chan(0, SPD0, 2'(m), bit_tbl[m]);
      push(0, 16'h5c3a ^ 16'(m));
      command(0, `OP_SINGLE, 16'h0000);
      check(take(0), (16'hb6e9 + 16'(m)) & mk);
      check(slave_rx(0), (16'h5c3a ^ 16'(m)) & mk);
      check(slave_per(0), 16'h0200);
      close_chan(0);
    end
    $display("test modes done");
    slave_words(0, 16'h0030);
    open_chan(0, SPD0, 2'h0, 5'h08);
    for (int i = 0; i < 8; i++) push(0, 16'h11a0 + 16'(i));
    check(16'(tx_ready[0]), 16'h0000);
    tx_valid[0] <= 1'b1;
    tx_data[0]  <= 16'hdead;
    repeat (3) @(posedge clk);
    tx_valid[0] <= 1'b0;
    command(0, `OP_BULK_WRITE, 16'h0007);
    check(16'(got_q[0].size()), 16'h0000);
    for (int i = 0; i < 7; i++) check(slave_rx(0), 16'h00a0 + 16'(i));
    command(0, `OP_SINGLE, 16'h0000);
    check(slave_rx(0), 16'h00a7);
    check(take(0), 16'h0037);
    command(0, `OP_BULK_READ, 16'h0003);
    for (int i = 0; i < 3; i++) check(take(0), 16'h0038 + 16'(i));
    for (int i = 0; i < 3; i++) check(slave_rx(0), 16'h0000);
    command(0, `OP_BULK_READ, 16'h0000);
    command(0, `OP_BULK_WRITE, 16'h0000);
    check(16'(g_slv[0].spi_slave_model_i.rx_q.size()), 16'h0000);
    check(16'({tx_ready[0], 7'(got_q[0].size())}), 16'h0080);
    close_chan(0);
    $display("test bulk done");
    slave_words(1, 16'h5a00);
    open_chan(1, 32'h000ee6b2, 2'h3, 5'h10);
    push(1, 16'hc3e1);
    command(1, `OP_SINGLE, 16'h0000);
    check(take(1), 16'h5a00);
    check(slave_rx(1), 16'hc3e1);
    check(slave_per(1), 16'h0400);
    check(16'({sclk_oe[0], opened[0]}), 16'h0000);
    close_chan(1);
    $display("test second channel done");
    open_chan(0, SPD0, 2'h1, 5'h10);
    push(0, 16'h1234);
    d0 = done_cnt[0];
    cmd_valid[0] <= 1'b1;
    cmd_op[0]    <= `OP_SINGLE;
    for (int i = 0; i < 200 && busy[0] !== 1'b1; i++) @(posedge clk);
    cmd_valid[0] <= 1'b0;
    repeat (20) @(posedge clk);
    close_chan(0);
    check(16'(done_cnt[0] - d0), 16'h0000);
    $display("test abort done");
    close_out();
  end

  // whole run is about 100 us; allow six times that
  initial begin
    #600000;
    errors++;
    close_out();
  end
endmodule : tb_spi_master_channel

bind spi_master_channel spi_master_channel_checker #(.NUM_CHANNELS(NUM_CHANNELS)) spi_master_channel_checker_i (
  .CLK_IN(CLK_IN), .RESET_N_IN(RESET_N_IN), .OPEN_IN(OPEN_IN), .CMD_VALID_IN(CMD_VALID_IN),
  .CMD_OP_IN(CMD_OP_IN), .CMD_READY_OUT(CMD_READY_OUT), .RX_VALID_OUT(RX_VALID_OUT), .DONE_OUT(DONE_OUT),
  .BUSY_OUT(BUSY_OUT), .OPENED_OUT(OPENED_OUT), .SCLK_OUT(SCLK_OUT), .SCLK_OE_OUT(SCLK_OE_OUT),
  .MOSI_OUT(MOSI_OUT), .MOSI_OE_OUT(MOSI_OE_OUT)
);

`default_nettype wire
